// [rtl/flash_page_command_sequencer.sv]
// Command sequencer for the data array and the program array
`timescale 1ns/100ps
// Overview of operation
// - Data array is 1024 four-byte pages
// - Four data registers plus high/low address
// - Eight-bit command register starts operations
// - Reset selects normal mode on data array
// - 01H reads page into data registers
// - 02H programs page below 0400H, pre-erased
// - 02H copies expanded RAM into program page
// - 04H verifies; command reads zero on match
// - 05H erases one data page
// - 05H erases 64-byte program page in mode
// - 06H erases whole selected array
// - 81H fetches one byte into byte0
// - 82H programs byte0 into addressed byte
// - F0H enters, 0FH leaves program-array mode
// - Reads and verifies take machine-cycle times
// - Normal-mode program and erase times
// - Program-array mode program and erase times
// - Command write starts operation at once
// - Core held until the operation ends
module flash_page_command_sequencer
   import flash_seq_pkg::*;
#(
   parameter int PAGE_PROG_CYC  = PAGE_PROG_CLKS,
   parameter int ERASE_CYC      = ERASE_CLKS,
   parameter int BYTE_PROG_CYC  = BYTE_PROG_CLKS,
   parameter int PROG_PAGE_CYC  = PROG_PAGE_CLKS
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [2:0]  sfr_sel,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             core_hold,
   output logic             program_array_mode,
   output logic      [7:0]  expanded_ram_addr,
   input  wire logic [7:0]  expanded_ram_rdata,
   output logic      [15:0] prog_addr,
   output logic      [7:0]  prog_wdata,
   output logic             prog_wr,
   output logic             prog_erase_page,
   output logic             prog_erase_all
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   data_array_if arr ();

   seq_state_t  state_ff;
   seq_state_t  nxt_state;
   logic [7:0]  flash_command_ff;
   logic [7:0]  flash_addr_high_ff;
   logic [7:0]  flash_addr_low_ff;
   logic [7:0]  page_data_regs_ff [PAGE_BYTES];
   logic        program_array_mode_ff;
   logic        nxt_mode;
   logic        core_hold_ff;
   logic [7:0]  sfr_rdata_ff;
   logic [7:0]  expanded_ram_addr_ff;
   logic [15:0] prog_addr_ff;
   logic [7:0]  prog_wdata_ff;
   logic        prog_wr_ff;
   logic        prog_erase_page_ff;
   logic        prog_erase_all_ff;

   logic        idle;
   logic        cmd_write;
   logic        page_ok;
   logic        byte_ok;
   logic        prog_ok;
   logic [1:0]  lane;
   logic [3:0]  mismatch;
   logic        timer_start;
   logic [CNT_W-1:0] timer_load;
   logic        timer_expired;
   logic        do_read_page;
   logic        do_read_byte;
   logic        do_verify;
   logic        do_prog_byte;
   logic        do_prog_erase_page;
   logic        do_prog_erase_all;
   logic        do_copy;

   // -----------------------------------------------------------------
   // Sub-blocks
   // -----------------------------------------------------------------
   data_array_store #(.PAGES(PAGE_COUNT)) u_store (
      .ref_clk (ref_clk),
      .rst     (rst),
      .arr     (arr.mem)
   );

   op_timer #(.W(CNT_W)) u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (timer_start),
      .load    (timer_load),
      .expired (timer_expired)
   );

   // -----------------------------------------------------------------
   // Address checks
   // -----------------------------------------------------------------
   // Out-of-range addresses are dropped rather than wrapped onto a page; 05H in program-array mode has no range check
   assign idle    = (state_ff == ST_IDLE);
   assign cmd_write = sfr_wr && idle && (sfr_sel == SEL_COMMAND);
   assign page_ok = (flash_addr_high_ff[7:2] == 6'h00);
   assign byte_ok = (flash_addr_high_ff[7:4] == 4'h0);
   assign prog_ok = (flash_addr_high_ff < PROG_HIGH_LIMIT);
   assign lane    = flash_addr_low_ff[1:0];

   // Per-byte compare of the data registers against the addressed page
   always_comb begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
         mismatch[b] = (arr.rd_word[b*8 +: 8] != page_data_regs_ff[b]);
      end
   end

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   // Work starts in the cycle of the command write; the array updates
   // on that same edge and the timer then holds the core
   always_comb begin
      nxt_mode           = program_array_mode_ff;
      timer_start        = 1'b0;
      timer_load         = '0;
      do_read_page       = 1'b0;
      do_read_byte       = 1'b0;
      do_verify          = 1'b0;
      do_prog_byte       = 1'b0;
      do_prog_erase_page = 1'b0;
      do_prog_erase_all  = 1'b0;
      do_copy            = 1'b0;
      arr.idx            = {flash_addr_high_ff[1:0], flash_addr_low_ff};
      arr.wr_mask        = 4'h0;
      arr.wr_data        = {page_data_regs_ff[3], page_data_regs_ff[2],
                            page_data_regs_ff[1], page_data_regs_ff[0]};
      arr.erase_page     = 1'b0;
      arr.erase_all      = 1'b0;
      if (cmd_write) begin
         case (sfr_wdata)
            CMD_READ_PAGE: begin
               if (!program_array_mode_ff && page_ok) begin
                  do_read_page = 1'b1;
                  timer_start  = 1'b1;
                  timer_load   = CNT_W'(PAGE_READ_CLKS);
               end
            end
            CMD_WRITE_PAGE: begin
               if (!program_array_mode_ff && page_ok) begin
                  arr.wr_mask = 4'hF;
                  timer_start = 1'b1;
                  timer_load  = CNT_W'(PAGE_PROG_CYC);
               end else if (program_array_mode_ff && prog_ok) begin
                  do_copy     = 1'b1;
                  timer_start = 1'b1;
                  timer_load  = CNT_W'(PROG_PAGE_CYC);
               end
            end
            CMD_VERIFY_PAGE: begin
               if (!program_array_mode_ff && page_ok) begin
                  do_verify   = 1'b1;
                  timer_start = 1'b1;
                  timer_load  = CNT_W'(PAGE_READ_CLKS);
               end
            end
            CMD_ERASE_PAGE: begin
               timer_load = CNT_W'(ERASE_CYC);
               if (!program_array_mode_ff && page_ok) begin
                  arr.erase_page = 1'b1;
                  timer_start    = 1'b1;
               end else if (program_array_mode_ff) begin
                  do_prog_erase_page = 1'b1;
                  timer_start        = 1'b1;
               end
            end
            CMD_ERASE_ALL: begin
               timer_load        = CNT_W'(ERASE_CYC);
               timer_start       = 1'b1;
               arr.erase_all     = !program_array_mode_ff;
               do_prog_erase_all = program_array_mode_ff;
            end
            CMD_SINGLE_BYTE_FETCH: begin
               if (!program_array_mode_ff && byte_ok) begin
                  arr.idx      = {flash_addr_high_ff[3:0], flash_addr_low_ff[7:2]};
                  do_read_byte = 1'b1;
                  timer_start  = 1'b1;
                  timer_load   = CNT_W'(BYTE_READ_CLKS);
               end
            end
            CMD_SINGLE_BYTE_PROG: begin
               timer_load = CNT_W'(BYTE_PROG_CYC);
               if (!program_array_mode_ff && byte_ok) begin
                  arr.idx     = {flash_addr_high_ff[3:0], flash_addr_low_ff[7:2]};
                  arr.wr_mask = 4'h1 << lane;
                  arr.wr_data = {4{page_data_regs_ff[0]}};
                  timer_start = 1'b1;
               end else if (program_array_mode_ff && prog_ok) begin
                  do_prog_byte = 1'b1;
                  timer_start  = 1'b1;
               end
            end
            CMD_ENTER_PROG_ARRAY: nxt_mode = 1'b1;
            CMD_LEAVE_PROG_ARRAY: nxt_mode = 1'b0;
            default: nxt_mode = program_array_mode_ff;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Sequencer state
   // -----------------------------------------------------------------
   // A short simulated program-page time cannot strand the copy: the
   // timed wait only checks expiry once the copy is over
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (timer_start) begin
               nxt_state = do_copy ? ST_COPY : ST_TIMED;
            end
         end
         ST_TIMED: begin
            if (timer_expired) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_COPY: begin
            if (expanded_ram_addr_ff == COPY_LAST_BYTE) begin
               nxt_state = ST_TIMED;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff     <= ST_IDLE;
         core_hold_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         core_hold_ff <= (nxt_state != ST_IDLE);
      end
   end

   // Mode selection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         program_array_mode_ff <= MODE_RESET;
      end else begin
         program_array_mode_ff <= nxt_mode;
      end
   end

   // -----------------------------------------------------------------
   // Software-visible registers
   // -----------------------------------------------------------------
   // Command readback holds the last code, or the verify mismatch mask
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flash_command_ff <= REG_RESET;
      end else if (do_verify) begin
         flash_command_ff <= {4'h0, mismatch};
      end else if (cmd_write) begin
         flash_command_ff <= sfr_wdata;
      end
   end

   // Address pair; writes are ignored while an operation runs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flash_addr_high_ff <= REG_RESET;
         flash_addr_low_ff  <= REG_RESET;
      end else if (sfr_wr && idle) begin
         if (sfr_sel == SEL_ADDR_HIGH) begin
            flash_addr_high_ff <= sfr_wdata;
         end
         if (sfr_sel == SEL_ADDR_LOW) begin
            flash_addr_low_ff <= sfr_wdata;
         end
      end
   end

   // Page data registers, loaded by software or by the read commands
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            page_data_regs_ff[b] <= REG_RESET;
         end
      end else if (sfr_wr && idle && sfr_sel >= SEL_DATA0 && sfr_sel <= SEL_DATA3) begin
         page_data_regs_ff[2'(sfr_sel - SEL_DATA0)] <= sfr_wdata;
      end else if (do_read_page) begin
         for (int b = 0; b < PAGE_BYTES; b++) begin
            page_data_regs_ff[b] <= arr.rd_word[b*8 +: 8];
         end
      end else if (do_read_byte) begin
         page_data_regs_ff[0] <= arr.rd_word[lane*8 +: 8];
      end
   end

   // Registered read port: data follows the select by one cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sfr_rdata_ff <= REG_RESET;
      end else if (sfr_sel == SEL_COMMAND) begin
         sfr_rdata_ff <= flash_command_ff;
      end else if (sfr_sel == SEL_ADDR_HIGH) begin
         sfr_rdata_ff <= flash_addr_high_ff;
      end else if (sfr_sel == SEL_ADDR_LOW) begin
         sfr_rdata_ff <= flash_addr_low_ff;
      end else if (sfr_sel >= SEL_DATA0 && sfr_sel <= SEL_DATA3) begin
         sfr_rdata_ff <= page_data_regs_ff[2'(sfr_sel - SEL_DATA0)];
      end else begin
         sfr_rdata_ff <= REG_RESET;  // Unused select reads zero
      end
   end

   // -----------------------------------------------------------------
   // Program array port
   // -----------------------------------------------------------------
   // Expanded RAM is walked from byte 0 while the copy runs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         expanded_ram_addr_ff <= 8'h00;
      end else if (do_copy) begin
         expanded_ram_addr_ff <= 8'h00;
      end else if (state_ff == ST_COPY && expanded_ram_addr_ff != COPY_LAST_BYTE) begin
         expanded_ram_addr_ff <= expanded_ram_addr_ff + 8'h01;
      end
   end

   // One-cycle strobes towards the program array; prog_wr stays high for all 256 copy cycles
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prog_addr_ff       <= 16'h0000;
         prog_wdata_ff      <= 8'h00;
         prog_wr_ff         <= 1'b0;
         prog_erase_page_ff <= 1'b0;
         prog_erase_all_ff  <= 1'b0;
      end else begin
         prog_wr_ff         <= 1'b0;
         prog_erase_page_ff <= do_prog_erase_page;
         prog_erase_all_ff  <= do_prog_erase_all;
         if (do_prog_byte) begin
            prog_addr_ff  <= {flash_addr_high_ff, flash_addr_low_ff};
            prog_wdata_ff <= page_data_regs_ff[0];
            prog_wr_ff    <= 1'b1;
         end else if (do_prog_erase_page) begin
            prog_addr_ff <= {flash_addr_high_ff, flash_addr_low_ff[7:6], 6'h00};
         end else if (state_ff == ST_COPY) begin
            prog_addr_ff  <= {flash_addr_high_ff, expanded_ram_addr_ff};
            prog_wdata_ff <= expanded_ram_rdata;
            prog_wr_ff    <= 1'b1;
         end
      end
   end

   assign sfr_rdata          = sfr_rdata_ff;
   assign core_hold          = core_hold_ff;
   assign program_array_mode = program_array_mode_ff;
   assign expanded_ram_addr  = expanded_ram_addr_ff;
   assign prog_addr          = prog_addr_ff;
   assign prog_wdata         = prog_wdata_ff;
   assign prog_wr            = prog_wr_ff;
   assign prog_erase_page    = prog_erase_page_ff;
   assign prog_erase_all     = prog_erase_all_ff;
endmodule : flash_page_command_sequencer

// [common/flash_seq_pkg.sv]
// Shared constants and types for the flash page command sequencer
package flash_seq_pkg;
   // -----------------------------------------------------------------
   // Register selects on the special-function register port
   // -----------------------------------------------------------------
   localparam logic [2:0] SEL_COMMAND   = 3'h0;
   localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
   localparam logic [2:0] SEL_ADDR_LOW  = 3'h2;
   localparam logic [2:0] SEL_DATA0     = 3'h3;  // Data byte k sits at SEL_DATA0 + k
   localparam logic [2:0] SEL_DATA3     = 3'h6;

   // -----------------------------------------------------------------
   // Command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_PAGE         = 8'h01;
   localparam logic [7:0] CMD_WRITE_PAGE        = 8'h02;
   localparam logic [7:0] CMD_VERIFY_PAGE       = 8'h04;
   localparam logic [7:0] CMD_ERASE_PAGE        = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL         = 8'h06;
   localparam logic [7:0] CMD_SINGLE_BYTE_FETCH = 8'h81;
   localparam logic [7:0] CMD_SINGLE_BYTE_PROG  = 8'h82;
   localparam logic [7:0] CMD_LEAVE_PROG_ARRAY  = 8'h0F;
   localparam logic [7:0] CMD_ENTER_PROG_ARRAY  = 8'hF0;

   // -----------------------------------------------------------------
   // Geometry, limits and reset values
   // -----------------------------------------------------------------
   localparam int         PAGE_COUNT      = 1024;
   localparam int         PAGE_BYTES      = 4;
   localparam int         IDX_W           = 10;
   localparam logic [7:0] PROG_HIGH_LIMIT = 8'hE0;
   localparam logic [7:0] COPY_LAST_BYTE  = 8'hFF;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic       MODE_RESET      = 1'b0;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CNT_W              = 19;
   localparam int CLK_PERIOD_NS      = 50;
   localparam int MACH_CYCLE_CLKS    = 12;
   localparam int PAGE_READ_MC       = 22;
   localparam int BYTE_READ_MC       = 9;
   localparam int PAGE_PROG_NS       = 380_000;
   localparam int ERASE_NS           = 2_000_000;
   localparam int BYTE_PROG_NS       = 200_000;
   localparam int PROG_PAGE_PROG_NS  = 16_500_000;
   localparam int PAGE_READ_CLKS     = PAGE_READ_MC * MACH_CYCLE_CLKS;
   localparam int BYTE_READ_CLKS     = BYTE_READ_MC * MACH_CYCLE_CLKS;
   localparam int PAGE_PROG_CLKS     = (PAGE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CLKS         = (ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BYTE_PROG_CLKS     = (BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_PAGE_CLKS     = (PROG_PAGE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TIMED = 2'b01,
      ST_COPY  = 2'b10
   } seq_state_t;
endpackage : flash_seq_pkg

// [common/data_array_if.sv]
// Port bundle between the sequencer and the data array storage
`timescale 1ns/100ps
interface data_array_if;
   logic [9:0]  idx;
   logic [3:0]  wr_mask;
   logic [31:0] wr_data;
   logic        erase_page;
   logic        erase_all;
   logic [31:0] rd_word;

   modport ctrl (output idx, output wr_mask, output wr_data, output erase_page,
                 output erase_all, input rd_word);
   modport mem  (input idx, input wr_mask, input wr_data, input erase_page,
                 input erase_all, output rd_word);
endinterface : data_array_if

// [rtl/op_timer.sv]
// Down counter that times one flash operation
`timescale 1ns/100ps
module op_timer
   import flash_seq_pkg::*;
#(
   parameter int W = CNT_W
)
(
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   output logic              expired
);
   logic [W-1:0] count_ff;

   // -----------------------------------------------------------------
   // Count
   // -----------------------------------------------------------------
   // Load on start, then run down to zero and rest there
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
      end else if (start) begin
         count_ff <= load;
      end else if (count_ff != '0) begin
         count_ff <= count_ff - 1'b1;
      end
   end

   assign expired = (count_ff == '0);
endmodule : op_timer

// [rtl/data_array_store.sv]
// Flip-flop storage of the data array, one word per page
`timescale 1ns/100ps
module data_array_store
   import flash_seq_pkg::*;
#(
   parameter int PAGES = PAGE_COUNT
)
(
   input wire logic ref_clk,
   input wire logic rst,
   data_array_if.mem arr
);
   logic [31:0] page_ff [PAGES];
   logic [31:0] lane_bits;

   // Widen the byte mask to a bit mask
   always_comb begin
      for (int b = 0; b < PAGE_BYTES; b++) begin
         lane_bits[b*8 +: 8] = {8{arr.wr_mask[b]}};
      end
   end

   // -----------------------------------------------------------------
   // Page storage
   // -----------------------------------------------------------------
   // Programming can only clear bits, so an unerased byte ends up as
   // the AND of old and new data, as a real cell would
   generate
      for (genvar i = 0; i < PAGES; i++) begin : g_page
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               page_ff[i] <= '1;
            end else if (arr.erase_all || (arr.erase_page && arr.idx == IDX_W'(i))) begin
               page_ff[i] <= '1;
            end else if ((|arr.wr_mask) && arr.idx == IDX_W'(i)) begin
               page_ff[i] <= page_ff[i] & (arr.wr_data | ~lane_bits);
            end
         end
      end
   endgenerate

   assign arr.rd_word = page_ff[arr.idx];
endmodule : data_array_store

// [verification/flash_seq_chk.sv]
// Port assertions for the flash page command sequencer
`timescale 1ns/100ps
module flash_seq_chk
   import flash_seq_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [2:0]  sfr_sel,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic [7:0]  sfr_rdata,
   input wire logic        core_hold,
   input wire logic        program_array_mode,
   input wire logic [15:0] prog_addr,
   input wire logic        prog_wr,
   input wire logic        prog_erase_page,
   input wire logic        prog_erase_all
);
   // ------------------------
   // Command writes that the sequencer takes
   // ------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire       cw   = sfr_wr && sfr_sel == SEL_COMMAND && !core_hold;  // Writes under hold drop
   wire [7:0] code = cw ? sfr_wdata : 8'h00;  // 00H is no command, so it never matches

   AST_ERASE_ALL_HOLD: assert property (code == CMD_ERASE_ALL |=>
      core_hold [*8]) else $error("erase did not hold");
   AST_UNDEF_CODE: assert property (code == 8'h03 |=>
      !core_hold && $stable(program_array_mode)) else $error("reserved code acted");
   AST_ENTER_MODE: assert property (code == CMD_ENTER_PROG_ARRAY |=>
      program_array_mode && !core_hold) else $error("mode entry failed");
   AST_LEAVE_MODE: assert property (code == CMD_LEAVE_PROG_ARRAY |=>
      !program_array_mode) else $error("mode exit failed");
   AST_MODE_KEPT: assert property (!cw |=> $stable(program_array_mode))
      else $error("mode changed unasked");
   AST_PROG_IN_MODE: assert property (prog_wr || prog_erase_page || prog_erase_all |->
      program_array_mode) else $error("array strobe in normal mode");
   AST_PAGE_ALIGN: assert property (prog_erase_page |-> prog_addr[5:0] == 6'h00)
      else $error("erase not aligned");
   AST_ERASE_STROBE: assert property (code == CMD_ERASE_ALL &&
      program_array_mode |=> prog_erase_all ##1 !prog_erase_all) else $error("bad erase strobe");
   AST_READ_NOOP: assert property (code == CMD_READ_PAGE && program_array_mode
      |=> !core_hold) else $error("page read ran in mode");
   AST_UNUSED_SEL: assert property (sfr_sel == 3'h7 |=> sfr_rdata == 8'h00)
      else $error("select 7 nonzero");

   // Main scenarios reached
   cover property (cw && sfr_wdata == CMD_WRITE_PAGE && program_array_mode);
   cover property ($fell(core_hold));
   cover property (prog_erase_page);
endmodule : flash_seq_chk

bind flash_page_command_sequencer flash_seq_chk u_chk (.ref_clk, .rst, .sfr_sel, .sfr_wr,
   .sfr_wdata, .sfr_rdata, .core_hold, .program_array_mode, .prog_addr, .prog_wr,
   .prog_erase_page, .prog_erase_all);

// [verification/far_side_model.sv]
// Expanded RAM and program array model
`timescale 1ns/100ps
module far_side_model (
   input  wire logic        ref_clk,
   input  wire logic [7:0]  expanded_ram_addr,
   output logic      [7:0]  expanded_ram_rdata,
   input  wire logic [15:0] prog_addr,
   input  wire logic [7:0]  prog_wdata,
   input  wire logic        prog_wr,
   input  wire logic        prog_erase_page,
   input  wire logic        prog_erase_all
);
   int          n_wr = 0;
   int          n_erase_all = 0;
   logic [15:0] last_addr;
   logic [7:0]  last_data;
   logic [15:0] erase_addr;
   // Patterned RAM makes copies traceable
   assign expanded_ram_rdata = expanded_ram_addr ^ 8'h5A;
   // Log program array strobes
   always @(posedge ref_clk) begin
      if (prog_wr) begin
         n_wr <= n_wr + 1;
         last_addr <= prog_addr;
         last_data <= prog_wdata;
      end
      if (prog_erase_page) erase_addr <= prog_addr;
      if (prog_erase_all) n_erase_all <= n_erase_all + 1;
   end
endmodule : far_side_model

// [verification/testbench.sv]
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
module testbench
   import flash_seq_pkg::*;
;
   localparam int EC = 30;   // Short counts keep the run brief
   localparam int PC = 20;
   localparam int BC = 25;
   localparam int GC = 300;  // Must be at least the 256-cycle copy
   logic        ref_clk, rst, sfr_wr, core_hold, program_array_mode;
   logic        prog_wr, prog_erase_page, prog_erase_all;
   logic [2:0]  sfr_sel;
   logic [7:0]  sfr_wdata, sfr_rdata, expanded_ram_addr, expanded_ram_rdata, prog_wdata;
   logic [15:0] prog_addr;
   int          errors, n_checks;

   flash_page_command_sequencer #(.PAGE_PROG_CYC(PC), .ERASE_CYC(EC), .BYTE_PROG_CYC(BC),
      .PROG_PAGE_CYC(GC)) dut (.ref_clk, .rst, .sfr_sel, .sfr_wr, .sfr_wdata, .sfr_rdata,
      .core_hold, .program_array_mode, .expanded_ram_addr, .expanded_ram_rdata, .prog_addr,
      .prog_wdata, .prog_wr, .prog_erase_page, .prog_erase_all);
   far_side_model u_far (.ref_clk, .expanded_ram_addr, .expanded_ram_rdata, .prog_addr,
      .prog_wdata, .prog_wr, .prog_erase_page, .prog_erase_all);

   // ------------------------
   // Access tasks
   // ------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_sel <= s;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask : wr
   // Read data lags the select by one edge
   task rd(input logic [2:0] s, input logic [7:0] e);
      @(posedge ref_clk);
      sfr_sel <= s;
      @(posedge ref_clk);
      #1 chk(sfr_rdata, e);
   endtask : rd
   task addr(input logic [7:0] h, input logic [7:0] l);
      wr(SEL_ADDR_HIGH, h);
      wr(SEL_ADDR_LOW, l);
   endtask : addr
   task data4(input logic [31:0] w);
      for (int k = 0; k < 4; k++) wr(SEL_DATA0 + 3'(k), w[8*k +: 8]);
   endtask : data4
   task chk4(input logic [31:0] w);
      for (int k = 0; k < 4; k++) rd(SEL_DATA0 + 3'(k), w[8*k +: 8]);
   endtask : chk4
   // Command, then count held cycles
   task automatic cmd(input logic [7:0] c, input int len);
      int n;
      wr(SEL_COMMAND, c);
      @(negedge ref_clk);
      while (core_hold === 1'b1 && n < 2000) begin
         n++;
         @(negedge ref_clk);
      end
      chk(n, len);
   endtask : cmd
   task finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   // ------------------------
   // Clock, watchdog and test sequence
   // ------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #1_000_000 errors++;
      finish_test;
   end
   initial begin
      {sfr_sel, sfr_wr, sfr_wdata, errors, n_checks} = '0;
      rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      for (int s = 0; s < 8; s++) rd(3'(s), 8'h00);
      chk(program_array_mode, 1'b0);
      cmd(CMD_ERASE_ALL, EC + 1);
      addr(8'h03, 8'hFC);
      data4(32'hC33C5AA5);
      cmd(CMD_WRITE_PAGE, PC + 1);
      data4(32'h0);
      cmd(CMD_READ_PAGE, 265);
      chk4(32'hC33C5AA5);
      cmd(CMD_VERIFY_PAGE, 265);
      rd(SEL_COMMAND, 8'h00);
      wr(SEL_DATA0 + 3'h2, 8'h00);
      cmd(CMD_VERIFY_PAGE, 265);
      rd(SEL_COMMAND, 8'h04);
      addr(8'h0F, 8'hF1);
      cmd(CMD_SINGLE_BYTE_FETCH, 109);
      rd(SEL_DATA0, 8'h5A);
      addr(8'h03, 8'hFC);
      cmd(CMD_ERASE_PAGE, EC + 1);
      cmd(CMD_READ_PAGE, 265);
      chk4(32'hFFFFFFFF);
      addr(8'h0F, 8'hFE);
      wr(SEL_DATA0, 8'h12);
      cmd(CMD_SINGLE_BYTE_PROG, BC + 1);
      wr(SEL_DATA0, 8'h00);
      cmd(CMD_SINGLE_BYTE_FETCH, 109);
      rd(SEL_DATA0, 8'h12);
      cmd(8'h03, 0);
      rd(SEL_DATA0, 8'h12);
      addr(8'h04, 8'h00);
      cmd(CMD_WRITE_PAGE, 0);
      cmd(CMD_ENTER_PROG_ARRAY, 0);
      chk(program_array_mode, 1'b1);
      cmd(CMD_READ_PAGE, 0);
      cmd(CMD_SINGLE_BYTE_FETCH, 0);
      cmd(CMD_ERASE_ALL, EC + 1);
      chk(u_far.n_erase_all, 1);
      addr(8'h12, 8'h47);
      cmd(CMD_ERASE_PAGE, EC + 1);
      chk(u_far.erase_addr, 16'h1240);
      wr(SEL_ADDR_LOW, 8'h41);
      wr(SEL_DATA0, 8'h77);
      cmd(CMD_SINGLE_BYTE_PROG, BC + 1);
      chk({u_far.last_addr, u_far.last_data}, 24'h124177);
      addr(8'hDF, 8'h00);
      cmd(CMD_WRITE_PAGE, GC + 1);
      chk(u_far.n_wr, 257);
      chk({u_far.last_addr, u_far.last_data}, 24'hDFFFA5);
      wr(SEL_ADDR_HIGH, 8'hE0);
      cmd(CMD_WRITE_PAGE, 0);
      cmd(CMD_LEAVE_PROG_ARRAY, 0);
      chk(program_array_mode, 1'b0);
      finish_test;
   end
endmodule : testbench
